/* File: logic/tsc_consts.svh */
// Constants of the test access port block: register lengths, capture values, buffer shape
`ifndef TSC_CONSTS_SVH
`define TSC_CONSTS_SVH

`define TSC_IR_W         8
`define TSC_IR_CAPTURE   8'h81
`define TSC_IR_BYPASS    8'hFF
`define TSC_DR_W         8
`define TSC_DR_RESET     8'h00
`define TSC_FIFO_W       8
`define TSC_FIFO_DEPTH   16
`define TSC_SYNC_STAGES  2

`endif

/* File: logic/tsc_pkg.sv */
// Types of the test access port block
package tsc_pkg;

    // Sixteen controller states, binary coded
    typedef enum logic [3:0] {
        TSC_RESET      = 4'h0,
        TSC_IDLE       = 4'h1,
        TSC_SEL_DR     = 4'h2,
        TSC_CAPTURE_DR = 4'h3,
        TSC_SHIFT_DR   = 4'h4,
        TSC_EXIT1_DR   = 4'h5,
        TSC_PAUSE_DR   = 4'h6,
        TSC_EXIT2_DR   = 4'h7,
        TSC_UPDATE_DR  = 4'h8,
        TSC_SEL_IR     = 4'h9,
        TSC_CAPTURE_IR = 4'hA,
        TSC_SHIFT_IR   = 4'hB,
        TSC_EXIT1_IR   = 4'hC,
        TSC_PAUSE_IR   = 4'hD,
        TSC_EXIT2_IR   = 4'hE,
        TSC_UPDATE_IR  = 4'hF
    } tsc_state_t;

endpackage

/* File: logic/tsc_sync.sv */
// Two-stage level synchroniser, parameterised width
`timescale 1ns/1ps
module tsc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_q;

    // First stage feeds only the second
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            meta_q <= '0;
            dout   <= '0;
        end
        else
        begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule // tsc_sync

/* File: logic/tsc_fifo.sv */
// Dual-clock FIFO with gray-coded pointers, valid/ready on both sides
`timescale 1ns/1ps
module tsc_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input  wire logic         wclk,
    input  wire logic         rclk,
    input  wire logic         nrst,
    input  wire logic         wvalid,
    output logic              wready,
    input  wire logic [W-1:0] wdata,
    output logic              rvalid,
    input  wire logic         rready,
    output logic      [W-1:0] rdata
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem [D];
    logic [W-1:0] rdata_q;
    logic [AW:0]  wbin_q;
    logic [AW:0]  wgray_q;
    logic [AW:0]  rbin_q;
    logic [AW:0]  rgray_q;
    logic [AW:0]  rgray_w;
    logic [AW:0]  wgray_r;
    logic [AW:0]  wbin_d;
    logic [AW:0]  rbin_d;
    logic         push;
    logic         pop;

    // Full and empty from synchronised gray pointers
    assign wready = (wgray_q != {~rgray_w[AW:AW-1], rgray_w[AW-2:0]});
    assign rvalid = (rgray_q != wgray_r);
    assign push   = wvalid && wready;
    assign pop    = rvalid && rready;
    assign wbin_d = wbin_q + {{AW{1'b0}}, 1'b1};
    assign rbin_d = rbin_q + {{AW{1'b0}}, 1'b1};
    assign rdata  = rdata_q;

    // Head word reloaded on every read clock, so it follows a pop at once
    always_ff @(posedge rclk)
    begin
        if (pop)
            rdata_q <= mem[rbin_d[AW-1:0]];
        else
            rdata_q <= mem[rbin_q[AW-1:0]];
    end

    // Write side storage
    always_ff @(posedge wclk)
    begin
        if (push)
            mem[wbin_q[AW-1:0]] <= wdata;
    end

    // Write pointer
    always_ff @(posedge wclk or negedge nrst)
    begin
        if (!nrst)
        begin
            wbin_q  <= '0;
            wgray_q <= '0;
        end
        else if (push)
        begin
            wbin_q  <= wbin_d;
            wgray_q <= wbin_d ^ (wbin_d >> 1);
        end
    end

    // Read pointer
    always_ff @(posedge rclk or negedge nrst)
    begin
        if (!nrst)
        begin
            rbin_q  <= '0;
            rgray_q <= '0;
        end
        else if (pop)
        begin
            rbin_q  <= rbin_d;
            rgray_q <= rbin_d ^ (rbin_d >> 1);
        end
    end

    // Pointer crossings
    tsc_sync #(.W(AW+1)) u_rsync (
        .clk  (wclk),
        .nrst (nrst),
        .din  (rgray_q),
        .dout (rgray_w)
    );

    tsc_sync #(.W(AW+1)) u_wsync (
        .clk  (rclk),
        .nrst (nrst),
        .din  (wgray_q),
        .dout (wgray_r)
    );
endmodule // tsc_fifo

/* File: logic/tsc_tap.sv */
// Test access port: controller, instruction, bypass and data registers, scan output timing
`timescale 1ns/1ps
`include "tsc_consts.svh"
module tsc_tap
    import tsc_pkg::*;
(
    input  wire logic                    sys_clk,
    input  wire logic                    nrst,
    input  wire logic                    tck,
    input  wire logic                    tms,
    input  wire logic                    tdi,
    output logic                         tdo,
    output logic                         tdo_oe,
    input  wire logic [`TSC_DR_W-1:0]    func_in,
    output logic      [`TSC_DR_W-1:0]    func_out,
    output logic                         func_out_oe,
    output logic                         rx_valid,
    input  wire logic                    rx_ready,
    output logic      [`TSC_FIFO_W-1:0]  rx_data,
    output logic                         bypass_sel
);

    tsc_state_t                state_q;
    tsc_state_t                state_d;
    logic [`TSC_IR_W-1:0]      ir_shift_q;
    logic [`TSC_IR_W-1:0]      ir_active_q;
    logic                      bypass_q;
    logic [`TSC_DR_W-1:0]      dr_shift_q;
    logic [`TSC_DR_W-1:0]      dr_out_q;
    logic                      tdo_q;
    logic                      tdo_oe_q;
    logic                      func_oe_q;
    logic                      is_bypass;
    logic                      scan_out;
    logic                      wr_valid;
    logic                      wr_ready;
    logic                      bypass_sys;

    // Instruction decode: all ones is bypass
    assign is_bypass = (ir_active_q == `TSC_IR_BYPASS);

    // Controller next state; mode-select sampled on the rising edge
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            TSC_RESET:      state_d = tms ? TSC_RESET : TSC_IDLE;
            TSC_IDLE:       state_d = tms ? TSC_SEL_DR : TSC_IDLE;
            TSC_SEL_DR:     state_d = tms ? TSC_SEL_IR : TSC_CAPTURE_DR;
            TSC_CAPTURE_DR: state_d = tms ? TSC_EXIT1_DR : TSC_SHIFT_DR;
            TSC_SHIFT_DR:   state_d = tms ? TSC_EXIT1_DR : TSC_SHIFT_DR;
            TSC_EXIT1_DR:   state_d = tms ? TSC_UPDATE_DR : TSC_PAUSE_DR;
            TSC_PAUSE_DR:   state_d = tms ? TSC_EXIT2_DR : TSC_PAUSE_DR;
            TSC_EXIT2_DR:   state_d = tms ? TSC_UPDATE_DR : TSC_SHIFT_DR;
            TSC_UPDATE_DR:  state_d = tms ? TSC_SEL_DR : TSC_IDLE;
            TSC_SEL_IR:     state_d = tms ? TSC_RESET : TSC_CAPTURE_IR;
            TSC_CAPTURE_IR: state_d = tms ? TSC_EXIT1_IR : TSC_SHIFT_IR;
            TSC_SHIFT_IR:   state_d = tms ? TSC_EXIT1_IR : TSC_SHIFT_IR;
            TSC_EXIT1_IR:   state_d = tms ? TSC_UPDATE_IR : TSC_PAUSE_IR;
            TSC_PAUSE_IR:   state_d = tms ? TSC_EXIT2_IR : TSC_PAUSE_IR;
            TSC_EXIT2_IR:   state_d = tms ? TSC_UPDATE_IR : TSC_SHIFT_IR;
            TSC_UPDATE_IR:  state_d = tms ? TSC_SEL_DR : TSC_IDLE;
            default:        state_d = TSC_RESET;
        endcase
    end

    // Controller state advances on the rising test-clock edge
    always_ff @(posedge tck or negedge nrst)
    begin
        if (!nrst)
            state_q <= TSC_RESET;
        else
            state_q <= state_d;
    end

    // Instruction shift register
    always_ff @(posedge tck or negedge nrst)
    begin
        if (!nrst)
            ir_shift_q <= `TSC_IR_CAPTURE;
        else if (state_q == TSC_CAPTURE_IR)
            ir_shift_q <= `TSC_IR_CAPTURE;
        else if (state_q == TSC_SHIFT_IR)
            ir_shift_q <= {tdi, ir_shift_q[`TSC_IR_W-1:1]};
    end

    // Active instruction, replaced on the falling edge
    always_ff @(negedge tck or negedge nrst)
    begin
        if (!nrst)
            ir_active_q <= `TSC_IR_BYPASS;
        else if (state_q == TSC_RESET)
            ir_active_q <= `TSC_IR_BYPASS;
        else if (state_q == TSC_UPDATE_IR)
            ir_active_q <= ir_shift_q;
    end

    // One-bit bypass register
    always_ff @(posedge tck or negedge nrst)
    begin
        if (!nrst)
            bypass_q <= 1'b0;
        else if (is_bypass && state_q == TSC_CAPTURE_DR)
            bypass_q <= 1'b0;
        else if (is_bypass && state_q == TSC_SHIFT_DR)
            bypass_q <= tdi;
    end

    // Data register: captures function inputs, shifts lsb first
    always_ff @(posedge tck or negedge nrst)
    begin
        if (!nrst)
            dr_shift_q <= `TSC_DR_RESET;
        else if (!is_bypass && state_q == TSC_CAPTURE_DR)
            dr_shift_q <= func_in;
        else if (!is_bypass && state_q == TSC_SHIFT_DR)
            dr_shift_q <= {tdi, dr_shift_q[`TSC_DR_W-1:1]};
    end

    // Output stage of the data register; loaded in Update-DR even when the buffer refuses the word
    always_ff @(negedge tck or negedge nrst)
    begin
        if (!nrst)
            dr_out_q <= `TSC_DR_RESET;
        else if (!is_bypass && state_q == TSC_UPDATE_DR)
            dr_out_q <= dr_shift_q;
    end

    // Test drive of the function outputs switches on the same edge as the active instruction
    always_ff @(negedge tck or negedge nrst)
    begin
        if (!nrst)
            func_oe_q <= 1'b0;
        else if (state_q == TSC_RESET)
            func_oe_q <= 1'b0;
        else if (state_q == TSC_UPDATE_IR)
            func_oe_q <= (ir_shift_q != `TSC_IR_BYPASS);
    end

    // Serial output source
    always_comb
    begin
        if (state_q == TSC_SHIFT_IR)
            scan_out = ir_shift_q[0];
        else if (is_bypass)
            scan_out = bypass_q;
        else
            scan_out = dr_shift_q[0];
    end

    // Serial output and its enable change on the falling edge
    always_ff @(negedge tck or negedge nrst)
    begin
        if (!nrst)
        begin
            tdo_q    <= 1'b0;
            tdo_oe_q <= 1'b0;
        end
        else
        begin
            tdo_q    <= scan_out;
            tdo_oe_q <= (state_q == TSC_SHIFT_IR) || (state_q == TSC_SHIFT_DR);
        end
    end

    assign tdo         = tdo_q;
    assign tdo_oe      = tdo_oe_q;
    assign func_out    = dr_out_q;
    assign func_out_oe = func_oe_q;

    // Updated data words enter the buffer on the edge leaving Update-DR
    assign wr_valid = !is_bypass && (state_q == TSC_UPDATE_DR);

    // Buffer from the test clock to the system clock
    tsc_fifo #(.W(`TSC_FIFO_W), .D(`TSC_FIFO_DEPTH)) u_fifo (
        .wclk   (tck),
        .rclk   (sys_clk),
        .nrst   (nrst),
        .wvalid (wr_valid),
        .wready (wr_ready),
        .wdata  (dr_shift_q),
        .rvalid (rx_valid),
        .rready (rx_ready),
        .rdata  (rx_data)
    );

    // Bypass selection seen by the system side
    tsc_sync #(.W(1)) u_byp_sync (
        .clk  (sys_clk),
        .nrst (nrst),
        .din  (is_bypass),
        .dout (bypass_sys)
    );

    assign bypass_sel = bypass_sys;

endmodule // tsc_tap

/* File: bench/tsc_tap_monitor.sv */
// Checker of the test access port block, bound to its ports
`timescale 1ns/1ps
module tsc_tap_monitor (
    input wire logic       sys_clk,
    input wire logic       nrst,
    input wire logic       tck,
    input wire logic       tms,
    input wire logic       tdo,
    input wire logic       tdo_oe,
    input wire logic [7:0] func_out,
    input wire logic       func_out_oe,
    input wire logic       rx_valid,
    input wire logic       rx_ready,
    input wire logic [7:0] rx_data,
    input wire logic       bypass_sel
);
    logic [10:0] out_q;

    // Outputs as they stand just before each rising edge
    always_ff @(posedge tck or negedge nrst)
    begin
        if (!nrst)
            out_q <= 11'h000;
        else
            out_q <= {func_out_oe, func_out, tdo_oe, tdo};
    end

    // Test clock domain
    tdo_hold_a: assert property (@(negedge tck) disable iff (!nrst)
        {tdo_oe, tdo} == out_q[1:0]) else $error("tdo moved on rise");
    fout_hold_a: assert property (@(negedge tck) disable iff (!nrst)
        {func_out_oe, func_out} == out_q[10:2]) else $error("func_out moved on rise");
    oe_off_a: assert property (@(negedge tck) disable iff (!nrst)
        tms |=> !tdo_oe) else $error("tdo driven outside shift");
    oe_keep_a: assert property (@(posedge tck) disable iff (!nrst)
        tdo_oe && !tms |=> tdo_oe) else $error("tdo released in shift");
    upd_only_a: assert property (@(negedge tck) disable iff (!nrst)
        !tms |=> $stable({func_out_oe, func_out})) else $error("update outside update");
    tlr_five_a: assert property (@(negedge tck) disable iff (!nrst)
        tms [*5] |=> !func_out_oe && !tdo_oe) else $error("no reset after five highs");
    // System clock domain
    byp_sync_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        $fell(func_out_oe) |-> ##[1:4] bypass_sel) else $error("bypass_sel late");
    rx_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        rx_valid && !rx_ready |=> rx_valid && $stable(rx_data)) else $error("rx word lost");

    // Main scenarios
    scan_c: cover property (@(posedge tck) disable iff (!nrst) tdo_oe && tms);
    pop_c: cover property (@(posedge sys_clk) disable iff (!nrst) rx_valid && rx_ready);
    byp_c: cover property (@(posedge sys_clk) disable iff (!nrst) $rose(bypass_sel));
endmodule // tsc_tap_monitor

bind tsc_tap tsc_tap_monitor u_tsc_tap_monitor (.sys_clk, .nrst, .tck, .tms, .tdo, .tdo_oe,
    .func_out, .func_out_oe, .rx_valid, .rx_ready, .rx_data, .bypass_sel);

/* File: bench/tsc_ctl_model.sv */
// Boundary-scan controller model driving the test clock, mode-select and serial input
`timescale 1ns/1ps
module tsc_ctl_model (
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo,
    input  wire logic tdo_oe
);
    logic oe_ok;

    // Clock stands low between frames
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        oe_ok = 1'b1;
    end

    // One cycle: levels set after the fall, read at the rise
    task automatic step(input logic m, input logic i, output logic o, output logic e);
        tms = m;
        tdi = i;
        #16 tck = 1'b1;
        o = tdo_oe ? tdo : ~tdo; // Released line reads inverted
        e = tdo_oe;
        #16 tck = 1'b0;
    endtask

    // Idle to shift, n bits lsb first, update, back to idle
    task automatic scan(input logic ir, input logic [7:0] din, input int n, output logic [7:0] dout);
        logic o, e;
        dout = 8'h00;
        oe_ok = 1'b1;
        step(1'b1, 1'b0, o, e);
        if (ir)
            step(1'b1, 1'b0, o, e);
        step(1'b0, 1'b0, o, e);
        step(1'b0, 1'b0, o, e);
        for (int k = 0; k < n; k++)
        begin
            step(k == n - 1, din[k], o, e);
            dout = {o, dout[7:1]};
            oe_ok &= e;
        end
        step(1'b1, 1'b0, o, e);
        oe_ok &= !e;
        step(1'b0, 1'b0, o, e);
    endtask
endmodule // tsc_ctl_model

/* File: bench/testbench.sv */
// Self-checking testbench of the test access port block
`timescale 1ns/1ps
`include "tsc_consts.svh"
module testbench;
    logic       sys_clk, nrst, tck, tms, tdi, tdo, tdo_oe, o, e;
    logic       func_out_oe, rx_valid, rx_ready, bypass_sel;
    logic [7:0] func_in, func_out, rx_data, d;
    int         miscompares, n_tests, cycles;

    tsc_tap u_tsc_tap (.sys_clk, .nrst, .tck, .tms, .tdi, .tdo, .tdo_oe, .func_in, .func_out,
        .func_out_oe, .rx_valid, .rx_ready, .rx_data, .bypass_sel);
    tsc_ctl_model u_ctl (.tck, .tms, .tdi, .tdo, .tdo_oe);

    // System clock
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Run limit
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            results();
        end
    end

    task automatic results;
        if (miscompares == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string s, input logic [7:0] x, input logic [7:0] g);
        n_tests++;
        if (g !== x)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", s, x, g);
        end
    endtask

    task automatic chk1(input string s, input logic x, input logic g);
        chk(s, {7'h00, x}, {7'h00, g});
    endtask

    task automatic sys(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // Released outputs in reset, bypass after release
    task automatic t_reset;
        chk1("tdo_oe", 1'b0, tdo_oe);
        chk1("func_out_oe", 1'b0, func_out_oe);
        chk1("rx_valid", 1'b0, rx_valid);
        nrst = 1'b1;
        sys(4);
        chk1("bypass_sel", 1'b1, bypass_sel);
        u_ctl.step(1'b0, 1'b0, o, e);
    endtask

    // Instruction scan with capture pattern and output enable
    task automatic t_ir(input logic [7:0] v, input logic oe);
        u_ctl.scan(1'b1, v, 8, d);
        chk("ir_capture", `TSC_IR_CAPTURE, d);
        chk1("ir_oe", 1'b1, u_ctl.oe_ok);
        sys(6);
        chk1("func_out_oe", oe, func_out_oe);
        chk1("bypass_sel", !oe, bypass_sel);
    endtask

    // Three bits through the one-stage bypass
    task automatic t_byp;
        u_ctl.scan(1'b0, 8'h05, 3, d);
        chk("bypass_out", 8'h02, {5'h00, d[7:5]});
        chk1("dr_oe", 1'b1, u_ctl.oe_ok);
    endtask

    // Data scan: capture, update, one word to the buffer
    task automatic t_dr(input logic [7:0] fi, input logic [7:0] w);
        @(negedge sys_clk) func_in = fi;
        u_ctl.scan(1'b0, w, 8, d);
        chk("dr_capture", fi, d);
        chk("func_out", w, func_out);
        sys(8);
        chk1("rx_valid", 1'b1, rx_valid);
        chk("rx_data", w, rx_data);
        rx_ready = 1'b1;
        sys(1);
        rx_ready = 1'b0;
        chk1("rx_valid", 1'b0, rx_valid);
    endtask

    // Fill buffer until refused, then drain back to back
    task automatic t_full;
        for (int i = 0; i < 17; i++)
            u_ctl.scan(1'b0, 8'(i), 8, d);
        chk("func_out", 8'h10, func_out);
        sys(8);
        rx_ready = 1'b1;
        for (int i = 0; i < 16; i++)
        begin
            chk1("rx_valid", 1'b1, rx_valid);
            chk("rx_data", 8'(i), rx_data);
            sys(1);
        end
        rx_ready = 1'b0;
        chk1("rx_valid", 1'b0, rx_valid);
    endtask

    // Five high mode-select edges restore bypass
    task automatic t_tlr;
        t_ir(8'h00, 1'b1);
        repeat (5) u_ctl.step(1'b1, 1'b0, o, e);
        sys(6);
        chk1("bypass_sel", 1'b1, bypass_sel);
        chk1("tdo_oe", 1'b0, tdo_oe);
        u_ctl.step(1'b0, 1'b0, o, e);
    endtask

    // Main sequence
    initial
    begin
        nrst = 1'b1;
        rx_ready = 1'b0;
        func_in = 8'h00;
        @(negedge sys_clk) nrst = 1'b0;
        sys(6);
        t_reset();
        t_ir(`TSC_IR_BYPASS, 1'b0);
        t_byp();
        t_byp();
        t_ir(8'h00, 1'b1);
        t_dr(8'hA5, 8'h3C);
        t_full();
        t_tlr();
        results();
    end
endmodule // testbench
